//--- hdl/spg_lfsr_step.sv
// PRBS7 word stepper: advances a seven-bit register by eight or ten bits.
// Assumes purely combinational use inside the generator and verifier.
`timescale 1ns/1ps
`default_nettype none
module spg_lfsr_step
(
   input wire logic [6:0] state_in,
   input wire logic wide_in,
   output logic [6:0] state_out,
   output logic [9:0] word_out
);
   // Serial unroll, x^7+x^6+1, first bit in word bit 0
   always_comb
   begin
      logic [6:0] s;
      s = state_in;
      word_out = 10'h000;
      for (int i = 0; i < 10; i++)
      begin
         if (i < 8 || wide_in)
         begin
            word_out[i] = s[6] ^ s[5];
            s = {s[5:0], s[6] ^ s[5]};
         end
      end
      state_out = s;
   end
endmodule
`default_nettype wire

//--- hdl/spg_pkg.sv
// Constants and types for the serial pattern generator and verifier.
// Assumes one parallel clock per channel; no register bus.
// Overview of operation
// - Generate pattern at 8 or 10 bits
// - Fixed 1111100000 only at 10, unchecked
// - Loopback feeds generator output to verifier
// - Complete flag after alignment and full cycle
// - Complete flag holds until receive reset
// - Error flag held at least three cycles
// - Error clears after clean following sequence
// - Transmit and receive resets act separately
// - Receive side shares clk_in with transmit side, unbonded
package spg_pkg;
   // Pattern selection
   typedef enum logic [1:0] {SPG_PAT_PRBS7 = 2'h0, SPG_PAT_LOWF = 2'h1, SPG_PAT_OFF = 2'h2} spg_pat_t;
   // Verifier states, Gray along the usual path
   typedef enum logic [1:0] {SPG_V_ALIGN = 2'h0, SPG_V_SEED = 2'h1, SPG_V_CYCLE = 2'h3, SPG_V_RUN = 2'h2} spg_vst_t;
   localparam int SPG_LFSR_W = 7;
   localparam logic [6:0] SPG_LFSR_SEED = 7'h7F;
   localparam logic [9:0] SPG_LOWF_WORD = 10'h3E0;
   localparam logic [6:0] SPG_PRBS_PERIOD = 7'h7F;
   localparam logic [1:0] SPG_ERR_HOLD = 2'h3;
   localparam logic [6:0] SPG_SEED_BITS = 7'h07;
endpackage

//--- hdl/spg_top.sv
// Pattern generator and verifier for one transceiver channel.
// Assumes rx side words on the same clock as the transmit side (clk_in) with alignment given.
`timescale 1ns/1ps
`default_nettype none
module spg_top
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic tx_logic_reset_in,
   input wire logic rx_logic_reset_in,
   input wire logic wide_in,
   input wire logic [1:0] pattern_sel_in,
   input wire logic loopback_in,
   input wire logic aligned_in,
   input wire logic [9:0] rx_data_in,
   output logic [9:0] tx_data_out,
   output logic verify_complete_flag_out,
   output logic verify_error_flag_out
);
   // Generator state
   logic [6:0] gen_lfsr, next_gen_lfsr;
   logic [9:0] tx_word, next_tx_word;
   logic [6:0] gen_nstate;
   logic [9:0] gen_word;
   // Verifier state
   spg_pkg::spg_vst_t vst, next_vst;
   logic [6:0] chk_lfsr, next_chk_lfsr;
   logic [6:0] cyc_cnt, next_cyc_cnt;
   logic [1:0] hold_cnt, next_hold_cnt;
   logic done, next_done;
   logic err, next_err;
   logic [6:0] chk_nstate;
   logic [9:0] chk_word;
   logic [9:0] rx_word;
   logic [9:0] mask;
   logic prbs_sel;

   // Newest seven received bits into predictor order; the shift register's
   // bit 0 holds the latest bit, so the word's top bits are reversed
   function automatic logic [6:0] spg_seed(input logic [9:0] word, input logic wide);
      logic [6:0] s;
      for (int i = 0; i < 7; i++)
      begin
         s[i] = wide ? word[9 - i] : word[7 - i];
      end
      return s;
   endfunction

   assign prbs_sel = (pattern_sel_in == spg_pkg::SPG_PAT_PRBS7);
   // Width mask for compare
   assign mask = wide_in ? 10'h3FF : 10'h0FF;
   // Loopback selects generated word as receive input
   assign rx_word = (loopback_in ? tx_word : rx_data_in) & mask;

   spg_lfsr_step u_gen_step
   (
      .state_in(gen_lfsr),
      .wide_in(wide_in),
      .state_out(gen_nstate),
      .word_out(gen_word)
   );

   spg_lfsr_step u_chk_step
   (
      .state_in(chk_lfsr),
      .wide_in(wide_in),
      .state_out(chk_nstate),
      .word_out(chk_word)
   );

   // Generator next values
   always_comb
   begin
      next_gen_lfsr = gen_lfsr;
      next_tx_word = 10'h000;
      if (tx_logic_reset_in)
      begin
         next_gen_lfsr = spg_pkg::SPG_LFSR_SEED;
      end
      else if (prbs_sel)
      begin
         next_gen_lfsr = gen_nstate;
         next_tx_word = gen_word & mask;
      end
      else if (pattern_sel_in == spg_pkg::SPG_PAT_LOWF && wide_in)
      begin
         // Fixed word only at ten bits; no check path
         next_tx_word = spg_pkg::SPG_LOWF_WORD;
      end
   end

   // Generator registers
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         gen_lfsr <= spg_pkg::SPG_LFSR_SEED;
         tx_word <= 10'h000;
      end
      else
      begin
         gen_lfsr <= next_gen_lfsr;
         tx_word <= next_tx_word;
      end
   end

   // Verifier next values; self-seeds from received bits
   always_comb
   begin
      next_vst = vst;
      next_chk_lfsr = chk_lfsr;
      next_cyc_cnt = cyc_cnt;
      next_hold_cnt = hold_cnt;
      next_done = done;
      next_err = err;
      if (rx_logic_reset_in || !prbs_sel)
      begin
         next_vst = spg_pkg::SPG_V_ALIGN;
         next_cyc_cnt = 7'h00;
         next_hold_cnt = 2'h0;
         next_err = 1'b0;
         if (rx_logic_reset_in)
         begin
            next_done = 1'b0;
         end
      end
      else
      begin
         case (vst)
            spg_pkg::SPG_V_ALIGN:
            begin
               // Wait for word boundary
               if (aligned_in)
               begin
                  next_vst = spg_pkg::SPG_V_SEED;
               end
            end
            spg_pkg::SPG_V_SEED:
            begin
               // Load last seven received bits as predictor state
               next_chk_lfsr = spg_seed(rx_word, wide_in);
               next_cyc_cnt = 7'h00;
               next_vst = spg_pkg::SPG_V_CYCLE;
            end
            spg_pkg::SPG_V_CYCLE:
            begin
               // Count one full period of clean words
               next_chk_lfsr = chk_nstate;
               if ((chk_word & mask) != rx_word)
               begin
                  next_vst = spg_pkg::SPG_V_SEED;
               end
               else if (cyc_cnt == spg_pkg::SPG_PRBS_PERIOD - 7'h01)
               begin
                  next_done = 1'b1;
                  next_cyc_cnt = 7'h00;
                  next_vst = spg_pkg::SPG_V_RUN;
               end
               else
               begin
                  next_cyc_cnt = cyc_cnt + 7'h01;
               end
            end
            default:
            begin
               // Running check after completion
               next_chk_lfsr = chk_nstate;
               next_cyc_cnt = (cyc_cnt == spg_pkg::SPG_PRBS_PERIOD - 7'h01) ? 7'h00 : cyc_cnt + 7'h01;
               if (hold_cnt != 2'h0)
               begin
                  next_hold_cnt = hold_cnt - 2'h1;
               end
               if ((chk_word & mask) != rx_word)
               begin
                  next_err = 1'b1;
                  next_hold_cnt = spg_pkg::SPG_ERR_HOLD - 2'h1;
                  next_cyc_cnt = 7'h00;
               end
               else if (err && hold_cnt == 2'h0 && cyc_cnt == spg_pkg::SPG_PRBS_PERIOD - 7'h01)
               begin
                  next_err = 1'b0;
               end
            end
         endcase
      end
   end

   // Verifier registers on clk_in, the same clock as the generator registers
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         vst <= spg_pkg::SPG_V_ALIGN;
         chk_lfsr <= spg_pkg::SPG_LFSR_SEED;
         cyc_cnt <= 7'h00;
         hold_cnt <= 2'h0;
         done <= 1'b0;
         err <= 1'b0;
      end
      else
      begin
         vst <= next_vst;
         chk_lfsr <= next_chk_lfsr;
         cyc_cnt <= next_cyc_cnt;
         hold_cnt <= next_hold_cnt;
         done <= next_done;
         err <= next_err;
      end
   end

   assign tx_data_out = tx_word;
   assign verify_complete_flag_out = done;
   assign verify_error_flag_out = err;

   // Error minimum hold counter
   logic [1:0] err_age;
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         err_age <= 2'h0;
      end
      else if (!err)
      begin
         err_age <= 2'h0;
      end
      else if (err_age != 2'h3)
      begin
         err_age <= err_age + 2'h1;
      end
   end

   AST_DONE_STICKY: assert property (@(posedge clk_in) disable iff (rst_in)
      done && !rx_logic_reset_in |=> done)
      else $error("complete flag dropped without reset");
   AST_DONE_RST: assert property (@(posedge clk_in) disable iff (rst_in)
      rx_logic_reset_in |=> !done && !err)
      else $error("receive reset did not clear flags");
   AST_ERR_AFTER_DONE: assert property (@(posedge clk_in) disable iff (rst_in)
      err |-> done)
      else $error("error flag before complete");
   AST_ERR_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(err) && !$past(rx_logic_reset_in) && $past(prbs_sel) |-> $past(err_age) >= 2'h2)
      else $error("error flag shorter than three cycles");
   AST_DONE_NEEDS_CYCLE: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(done) |-> $past(vst) == spg_pkg::SPG_V_CYCLE)
      else $error("complete without full cycle");
   AST_TX_RESET: assert property (@(posedge clk_in) disable iff (rst_in)
      tx_logic_reset_in |=> tx_word == 10'h000 && gen_lfsr == spg_pkg::SPG_LFSR_SEED)
      else $error("generator not reset");
   AST_LOWF: assert property (@(posedge clk_in) disable iff (rst_in)
      !tx_logic_reset_in && pattern_sel_in == spg_pkg::SPG_PAT_LOWF && wide_in
      |=> tx_word == spg_pkg::SPG_LOWF_WORD && !err)
      else $error("low frequency word wrong");
   AST_NARROW: assert property (@(posedge clk_in) disable iff (rst_in)
      !wide_in |=> tx_word[9:8] == 2'h0 || $past(wide_in, 2))
      else $error("narrow width drove upper bits");
   AST_RESYNC: assert property (@(posedge clk_in) disable iff (rst_in)
      rx_logic_reset_in |=> vst == spg_pkg::SPG_V_ALIGN)
      else $error("receive reset did not restart sync");

   COV_DONE: cover property (@(posedge clk_in) disable iff (rst_in) $rose(done));
   COV_ERR: cover property (@(posedge clk_in) disable iff (rst_in) $rose(err));
   COV_ERR_CLR: cover property (@(posedge clk_in) disable iff (rst_in) $fell(err) && done);
   COV_LOOP: cover property (@(posedge clk_in) disable iff (rst_in) loopback_in && done);
endmodule
`default_nettype wire

//--- verif/spg_link_model.sv
// Channel model between generator output and verifier input.
// Assumes bench drives the error mask from clk_in edges.
`timescale 1ns/1ps
`default_nettype none
module spg_link_model
(
   input wire logic [9:0] tx_data_in,
   input wire logic [9:0] flip_in,
   output logic [9:0] rx_data_out
);
   // Wire with injected bit errors; clean when flip_in is zero
   assign rx_data_out = tx_data_in ^ flip_in;
endmodule
`default_nettype wire

//--- verif/spg_top_bench.sv
// Self-checking bench for the pattern generator and verifier.
// Assumes spg_top and spg_link_model compiled first.
`timescale 1ns/1ps
`default_nettype none
module spg_top_bench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic txr = 1'b0; // Transmit reset
   logic rxr = 1'b0; // Receive reset
   logic wide = 1'b1;
   logic [1:0] sel = 2'h2;
   logic lb = 1'b0; // Loopback
   logic al = 1'b0; // Aligned
   logic wob = 1'b0; // Random noise on rx
   logic [9:0] inj = 10'h000;
   logic [9:0] flip = 10'h000;
   logic [16:0] rnd = 17'h12430;
   logic [9:0] rx;
   logic [9:0] tx;
   logic vc;
   logic ve;
   logic [9:0] w;
   logic [11:0] note_q[$]; // Kind and expected value
   logic [11:0] n;
   logic [9:0] seen;
   string nm[4] = '{"tx_data", "complete", "error", "tx_high"};
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   // Clock, 5 ns period
   initial forever #2.5 clk_in = ~clk_in;
   // Device under test
   spg_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .tx_logic_reset_in(txr), .rx_logic_reset_in(rxr),
      .wide_in(wide), .pattern_sel_in(sel), .loopback_in(lb), .aligned_in(al), .rx_data_in(rx),
      .tx_data_out(tx), .verify_complete_flag_out(vc), .verify_error_flag_out(ve));
   // Far-side channel
   spg_link_model i_link (.tx_data_in(tx), .flip_in(flip), .rx_data_out(rx));
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   // Random stream and error mask drive
   always @(posedge clk_in)
   begin
      rnd <= lfsr(rnd);
      flip <= wob ? rnd[9:0] : inj;
   end
   // Verdict and end of run
   task finish_test();
      if (failures == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         finish_test();
      end
   end
   // Output watcher: every note pending at a falling edge is compared there
   always @(negedge clk_in)
   begin
      while (note_q.size() > 0)
      begin
         n = note_q.pop_front();
         case (n[11:10])
            2'h0: seen = tx;
            2'h1: seen = {9'h000, vc};
            2'h2: seen = {9'h000, ve};
            default: seen = {8'h00, tx[9:8]};
         endcase
         checked++;
         if (seen !== n[9:0])
         begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", nm[n[11:10]], n[9:0], seen);
         end
      end
   end
   task note(input logic [1:0] k, input logic [9:0] v);
      note_q.push_back({k, v});
   endtask
   task step(input int c);
      repeat (c) @(posedge clk_in);
   endtask
   // Bounded wait for a flag level, then note it
   task wait_flag(input logic [1:0] k, input logic v, input int c);
      for (int i = 0; i < c; i++)
      begin
         @(negedge clk_in);
         if (((k == 2'h1) ? vc : ve) === v)
            break;
      end
      // Back on a rising edge, so the note is checked at the next fall
      @(posedge clk_in);
      note(k, {9'h000, v});
   endtask
   // Main sequence
   initial
   begin
      step(6);
      rst_in <= 1'b0;
      note(2'h0, 10'h000);
      note(2'h1, 10'h000);
      note(2'h2, 10'h000);
      sel <= 2'h1;
      al <= 1'b1;
      step(2);
      note(2'h0, 10'h3E0);
      wide <= 1'b0;
      step(2);
      note(2'h0, 10'h000);
      step(200);
      note(2'h1, 10'h000);
      for (int i = 2; i < 4; i++)
      begin
         sel <= i[1:0];
         step(2);
         note(2'h0, 10'h000);
      end
      // PRBS at both widths over loopback, rx noise ignored
      sel <= 2'h0;
      lb <= 1'b1;
      wob <= 1'b1;
      al <= 1'b0;
      step(300);
      note(2'h1, 10'h000);
      for (int k = 0; k < 2; k++)
      begin
         wide <= k[0];
         rxr <= 1'b1;
         step(1);
         rxr <= 1'b0;
         al <= 1'b1;
         step(1);
         note(2'h1, 10'h000);
         step(100);
         note(2'h1, 10'h000);
         wait_flag(2'h1, 1'b1, 60);
         @(negedge clk_in);
         w = tx;
         // One pattern period is 127 words at either width
         repeat (127) @(posedge clk_in);
         note(2'h0, w);
         note(2'h3, {8'h00, w[9:8] & {2{k[0]}}});
      end
      al <= 1'b0;
      step(40);
      note(2'h1, 10'h001);
      // Error injection on the received side
      wob <= 1'b0;
      step(2);
      lb <= 1'b0;
      step(3);
      note(2'h2, 10'h000);
      inj <= rnd[9:0] | 10'h001;
      step(1);
      inj <= 10'h000;
      wait_flag(2'h2, 1'b1, 5);
      step(1);
      note(2'h2, 10'h001);
      step(1);
      note(2'h2, 10'h001);
      step(90);
      note(2'h2, 10'h001);
      wait_flag(2'h2, 1'b0, 60);
      note(2'h1, 10'h001);
      // Raise the error again, then let the receive reset clear it
      inj <= 10'h004;
      step(1);
      inj <= 10'h000;
      wait_flag(2'h2, 1'b1, 5);
      rxr <= 1'b1;
      step(1);
      rxr <= 1'b0;
      step(1);
      note(2'h1, 10'h000);
      note(2'h2, 10'h000);
      txr <= 1'b1;
      step(2);
      note(2'h0, 10'h000);
      txr <= 1'b0;
      step(4);
      finish_test();
   end
endmodule
`default_nettype wire
